// ---- hdl/sai_pkg.sv ----
`default_nettype none
package sai_pkg;
   localparam int SAI_W = 14;
   localparam int SAI_CLK_MHZ = 125;
   localparam int SAI_FIFO_DEPTH = 8;
   // Conversion length in ns; core clock is internal, value is a plain default
   localparam int SAI_CONV_NS = 7000;
   localparam int SAI_CONV_CYC = (SAI_CONV_NS * SAI_CLK_MHZ) / 1000;
   // Hold phase before returning to track
   localparam int SAI_HOLD_NS = 1000;
   localparam int SAI_HOLD_CYC = (SAI_HOLD_NS * SAI_CLK_MHZ) / 1000;
   // Settling of the track stage, 1.5 us max
   localparam int SAI_SETTLE_NS = 1500;
   localparam int SAI_SETTLE_CYC = (SAI_SETTLE_NS * SAI_CLK_MHZ + 999) / 1000;
   // Track must lead next conversion by more than 2 us
   localparam int SAI_TRACK_LEAD_NS = 2000;
   localparam int SAI_TRACK_LEAD_CYC =
      (SAI_TRACK_LEAD_NS * SAI_CLK_MHZ + 999) / 1000;
   // Internal logic reset after power-up, 10 us
   localparam int SAI_PWRUP_US = 10;
   localparam int SAI_PWRUP_CYC = SAI_PWRUP_US * SAI_CLK_MHZ;
   localparam int SAI_CNT_W = 11;
   localparam logic [SAI_W-1:0] SAI_MSB_FLIP = 14'h2000;
   localparam logic [SAI_W-1:0] SAI_RESULT_RST = 14'h0000;

   typedef enum logic [1:0] {
      SAI_ST_PWRUP = 2'b00,
      SAI_ST_IDLE = 2'b01,
      SAI_ST_HOLD = 2'b10,
      SAI_ST_TRACK = 2'b11
   } sai_state_t;

   // Host-side control pins
   typedef struct packed {
      logic start_convert_n;
      logic chip_select_n;
      logic output_enable_n;
      logic done_flag_drive_enable_n;
      logic offset_mode_pin;
   } sai_ctrl_t;

   // Three-state pin pair: data and per-line enable
   typedef struct packed {
      logic [SAI_W-1:0] data;
      logic [SAI_W-1:0] oe;
   } sai_bus_out_t;
endpackage
`default_nettype wire

// ---- hdl/sai_fifo.sv ----
`default_nettype none
module sai_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = wr_q == rd_q;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // sai_fifo
`default_nettype wire

// ---- hdl/sai_top.sv ----
`default_nettype none
// Behaviour
// - Falling edge of start strobe begins conversion, chip select ignored.
// - Idle: done flag high, sample-hold tracking.
// - Converting: sample-hold holds for the first 1 us, done flag low throughout.
// - Done flag rises on completion; new result reaches the bus one cycle later.
// - Done flag driven only while its enable is low, else high-Z.
// - Result bus driven only when chip select and output enable low.
// - Whole 14-bit word in one read, MSB on highest line.
// - Straight binary unipolar, twos complement bipolar by offset pin.
// - Sample-hold re-tracks during conversion, over 2 us before next.
module sai_top
   import sai_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Host pins
   input wire sai_pkg::sai_ctrl_t ctrl,
   // Raw straight-binary code from the converter core
   input wire logic [sai_pkg::SAI_W-1:0] core_code,
   // Done flag pin
   output logic done_flag_o,
   output logic done_flag_oe,
   // Result bus pins
   output sai_pkg::sai_bus_out_t result_bus,
   // Analog control
   output logic track_mode,
   // Back-pressure: result queue can take another conversion
   output logic result_room
);
   import sai_pkg::*;

   logic rst_s1_q;
   logic rst_q;
   sai_ctrl_t sync1_q;
   sai_ctrl_t sync2_q;
   sai_ctrl_t sync3_q;
   sai_ctrl_t pins_q;
   sai_state_t state_q;
   logic [SAI_CNT_W-1:0] cnt_q;
   logic [SAI_W-1:0] result_q;
   logic sc_fall;
   logic conv_done;
   logic [SAI_W-1:0] coded;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [SAI_W-1:0] fifo_out_data;
   logic bus_en;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_q <= rst_s1_q;
      end
   end

   // Pins are asynchronous; change counts once stages two and three agree
   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         sync1_q <= '1;
         sync2_q <= '1;
         sync3_q <= '1;
      end
      else
      begin
         sync1_q <= ctrl;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // A pin level counts only once stages two and three agree
   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         pins_q <= '1;
      end
      else
      begin
         pins_q <= (sync3_q & ~(sync2_q ^ sync3_q)) |
                   (pins_q & (sync2_q ^ sync3_q));
      end
   end

   // Chip select plays no part in starting
   assign sc_fall = pins_q.start_convert_n && !sync3_q.start_convert_n &&
                    !sync2_q.start_convert_n;
   assign conv_done = (state_q == SAI_ST_TRACK) && (cnt_q == '0);

   // Straight binary or twos complement by inverting the MSB
   assign coded = pins_q.offset_mode_pin ? (core_code ^ SAI_MSB_FLIP)
                                         : core_code;

   // Start only when the queue has room; a start that finds it full is lost
   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         state_q <= SAI_ST_PWRUP;
         cnt_q <= SAI_CNT_W'(SAI_PWRUP_CYC - 1);
      end
      else
      begin
         case (state_q)
            SAI_ST_PWRUP:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= SAI_ST_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            SAI_ST_IDLE:
            begin
               if (sc_fall && fifo_in_ready)
               begin
                  state_q <= SAI_ST_HOLD;
                  cnt_q <= SAI_CNT_W'(SAI_HOLD_CYC - 1);
               end
            end
            SAI_ST_HOLD:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= SAI_ST_TRACK;
                  cnt_q <= SAI_CNT_W'(SAI_CONV_CYC - SAI_HOLD_CYC - 1);
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            SAI_ST_TRACK:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= SAI_ST_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default:
            begin
               state_q <= SAI_ST_IDLE;
            end
         endcase
      end
   end

   // Finished words pass through the queue, drained every cycle into the output register
   sai_fifo #(
      .WIDTH(SAI_W),
      .DEPTH(SAI_FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst_n(rst_q),
      .in_valid(conv_done),
      .in_ready(fifo_in_ready),
      .in_data(coded),
      .out_valid(fifo_out_valid),
      .out_ready(1'b1),
      .out_data(fifo_out_data)
   );

   // Output register loads only on completion, so reads stay stable
   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         result_q <= SAI_RESULT_RST;
      end
      else if (fifo_out_valid)
      begin
         result_q <= fifo_out_data;
      end
   end

   assign bus_en = !pins_q.chip_select_n && !pins_q.output_enable_n;

   // Flag level is kept even while its pin floats
   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         done_flag_o <= 1'b1;
      end
      else
      begin
         done_flag_o <= !((state_q == SAI_ST_HOLD) ||
                          (state_q == SAI_ST_TRACK));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         done_flag_oe <= 1'b0;
      end
      else
      begin
         done_flag_oe <= !pins_q.done_flag_drive_enable_n;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         track_mode <= 1'b1;
      end
      else
      begin
         track_mode <= state_q != SAI_ST_HOLD;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         result_room <= 1'b0;
      end
      else
      begin
         result_room <= fifo_in_ready;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_q)
   begin
      if (!rst_q)
      begin
         result_bus <= '0;
      end
      else
      begin
         result_bus.data <= result_q;
         result_bus.oe <= {SAI_W{bus_en}};
      end
   end

   a_start_holds: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      (state_q == SAI_ST_IDLE && sc_fall && fifo_in_ready)
      |=> ##1 (!done_flag_o && !track_mode))
      else $error("start did not enter hold");
   a_idle_flag: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      $past(state_q) == SAI_ST_IDLE |-> (done_flag_o && track_mode))
      else $error("idle flag or track wrong");
   a_pwrup_quiet: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      state_q == SAI_ST_PWRUP |=> (done_flag_o && track_mode))
      else $error("flag or track moved during power-up");
   a_conv_low: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      $fell(done_flag_o) |-> !done_flag_o [*8])
      else $error("done flag rose too early");
   a_done_rise: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      conv_done |=> ##1 done_flag_o)
      else $error("done flag did not rise");
   a_flag_gate: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      done_flag_oe == !$past(pins_q.done_flag_drive_enable_n))
      else $error("flag enable wrong");
   a_bus_gate: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      (pins_q.chip_select_n || pins_q.output_enable_n)
      |=> result_bus.oe == '0)
      else $error("bus driven while deselected");
   a_bus_on: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      (!pins_q.chip_select_n && !pins_q.output_enable_n)
      |=> result_bus.oe == '1)
      else $error("bus not driven while selected");
   a_result_word: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      conv_done |=> ##2 result_bus.data == $past(coded, 3))
      else $error("result word mismatch");
   a_coding: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      conv_done |=> ##2
      (result_bus.data[SAI_W-2:0] == $past(core_code[SAI_W-2:0], 3)) &&
      (result_bus.data[SAI_W-1] == ($past(core_code[SAI_W-1], 3) ^
      $past(pins_q.offset_mode_pin, 3))))
      else $error("result coding wrong");
   a_track_back: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      $rose(track_mode) |-> !done_flag_o ##1 !done_flag_o)
      else $error("track not resumed mid conversion");
   a_result_stable: assert property (@(posedge sys_clk)
      disable iff (!rst_q)
      !fifo_out_valid |=> $stable(result_q))
      else $error("result changed mid conversion");
endmodule // sai_top
`default_nettype wire

// ---- test/sai_host_model.sv ----
`default_nettype none
module sai_host_model (
   // Clock
   input wire logic clk,
   // Host pins
   output var sai_pkg::sai_ctrl_t ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   import sai_pkg::*;
   // Pulse and gap lengths are plain defaults
   localparam int TCP_CYC = 4;
   localparam int TCD_CYC = 4;

   initial ctrl = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

   task automatic start_pulse();
      @(negedge clk);
      ctrl.start_convert_n = 1'b0;
      repeat (TCP_CYC) @(negedge clk);
      ctrl.start_convert_n = 1'b1;
   endtask

   task automatic set_pins(input logic cs_n, input logic oe_n);
      @(negedge clk);
      ctrl.chip_select_n = cs_n;
      ctrl.output_enable_n = oe_n;
      repeat (6) @(negedge clk);
   endtask

   task automatic release_bus();
      set_pins(1'b1, 1'b1);
      repeat (TCD_CYC) @(negedge clk);
   endtask

   task automatic set_mode(input logic bip, input logic flag_en_n);
      @(negedge clk);
      ctrl.offset_mode_pin = bip;
      ctrl.done_flag_drive_enable_n = flag_en_n;
      repeat (6) @(negedge clk);
   endtask

   // Internal logic needs its power-up time before any start
   task automatic power_wait();
      repeat (1300) @(negedge clk);
   endtask
endmodule // sai_host_model
`default_nettype wire

// ---- test/tb_sampling_adc_bus_interface.sv ----
`default_nettype none
module tb_sampling_adc_bus_interface;
   timeunit 1ns;
   timeprecision 1ps;
   import sai_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   sai_ctrl_t ctrl;
   logic [SAI_W-1:0] core_code = 14'h0000;
   logic done_flag_o;
   logic done_flag_oe;
   sai_bus_out_t result_bus;
   logic track_mode;
   logic result_room;
   logic [SAI_W-1:0] prev_exp = 14'h0000;
   int n_errors = 0;
   int compares = 0;

   sai_top uut (.sys_clk(sys_clk), .nrst(nrst), .ctrl(ctrl),
      .core_code(core_code), .done_flag_o(done_flag_o),
      .done_flag_oe(done_flag_oe), .result_bus(result_bus),
      .track_mode(track_mode), .result_room(result_room));
   sai_host_model host (.clk(sys_clk), .ctrl(ctrl));

   always #4 sys_clk = ~sys_clk;

   task automatic check(input logic [SAI_W-1:0] got,
      input logic [SAI_W-1:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t ns: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask

   task automatic wait_flag(input logic val, input int max, output int n);
      n = 0;
      while (done_flag_o !== val && n < max)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask

   task automatic t_idle();
      int n;
      repeat (10) @(negedge sys_clk);
      check({13'h0000, done_flag_o}, 14'h0001, "idle flag");
      check({13'h0000, track_mode}, 14'h0001, "idle track");
      // Starts inside the power-up wait are dropped
      host.start_pulse();
      wait_flag(1'b0, 12, n);
      check({13'h0000, done_flag_o}, 14'h0001, "early start");
      host.power_wait();
   endtask

   task automatic t_convert(input logic bip, input logic cs_n,
      input logic [SAI_W-1:0] code);
      int n;
      logic [SAI_W-1:0] exp;
      exp = bip ? (code ^ 14'h2000) : code;
      // Core word moves after the flag falls; only the final one counts
      core_code = ~code;
      host.set_mode(bip, 1'b0);
      host.set_pins(cs_n, 1'b1);
      check(result_bus.oe, 14'h0000, "bus off");
      host.start_pulse();
      wait_flag(1'b0, 12, n);
      check({13'h0000, done_flag_o}, 14'h0000, "flag low");
      check({13'h0000, track_mode}, 14'h0000, "hold");
      core_code = code;
      host.set_pins(1'b0, 1'b0);
      check(result_bus.oe, 14'h3FFF, "bus on");
      check(result_bus.data, prev_exp, "old result");
      host.release_bus();
      n = 0;
      while (track_mode !== 1'b1 && n < 200)
      begin
         @(negedge sys_clk);
         n++;
      end
      check({13'h0000, track_mode}, 14'h0001, "re-track");
      check({13'h0000, done_flag_o}, 14'h0000, "still low");
      wait_flag(1'b1, 900, n);
      check({13'h0000, n >= SAI_TRACK_LEAD_CYC}, 14'h0001, "lead");
      check({13'h0000, done_flag_o}, 14'h0001, "flag high");
      host.set_pins(1'b0, 1'b0);
      check(result_bus.data, exp, "result");
      host.release_bus();
      prev_exp = exp;
   endtask

   task automatic t_tristate();
      host.set_pins(1'b1, 1'b0);
      check(result_bus.oe, 14'h0000, "cs high");
      host.set_pins(1'b0, 1'b1);
      check(result_bus.oe, 14'h0000, "oe high");
      host.set_mode(1'b0, 1'b1);
      check({13'h0000, done_flag_oe}, 14'h0000, "flag off");
      host.set_mode(1'b0, 1'b0);
      check({13'h0000, done_flag_oe}, 14'h0001, "flag on");
      check({13'h0000, done_flag_o}, 14'h0001, "flag idle");
      check({13'h0000, result_room}, 14'h0001, "room");
      host.release_bus();
   endtask

   task automatic close_out();
      $display("Counts: %0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      t_idle();
      t_convert(1'b0, 1'b1, 14'h3A5C);
      t_convert(1'b1, 1'b0, 14'h0ABC);
      t_convert(1'b1, 1'b0, 14'h3FFF);
      t_convert(1'b0, 1'b0, 14'h0000);
      t_tristate();
      close_out();
   end

   // Whole run is near 40 us; a hang is cut well beyond that
   initial
   begin
      #200000;
      n_errors++;
      close_out();
   end
endmodule // tb_sampling_adc_bus_interface
`default_nettype wire
